//--- include/hos_pkg.sv
// shared constants and types of the harmonic overcurrent stage
package hos_pkg;
  localparam int CLK_PERIOD_NS   = 10;
  localparam int STAMP_RES_NS    = 1000000;
  localparam int HOS_MS_CYCLES   = STAMP_RES_NS / CLK_PERIOD_NS;
  localparam int EVAL_PERIOD_MS  = 5;
  localparam int PREFAULT_MS     = 20;
  localparam int PREFAULT_DEPTH  = PREFAULT_MS / EVAL_PERIOD_MS;
  localparam int NUM_GROUPS      = 8;
  localparam int NUM_CHAN        = 5;
  localparam int NUM_PHASE       = 3;
  localparam int MAG_W           = 16;
  localparam int NUM_COMP        = 12;
  localparam int RESET_PCT       = 97;
  localparam int PCT_FULL        = 100;
  localparam int PCT_SCALE       = 10000;
  localparam int CH_RES_ONE      = 3;
  localparam int CH_RES_TWO      = 4;
  localparam int COMP_FUND       = 0;
  localparam int IEC_SHIFT       = 8;
  // byte offsets of the register map
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] CMD_OFS   = 8'h04;
  localparam logic [7:0] STAT_OFS  = 8'h08;
  localparam logic [7:0] SCNT_OFS  = 8'h0c;
  localparam logic [7:0] TCNT_OFS  = 8'h10;
  localparam logic [7:0] BCNT_OFS  = 8'h14;
  localparam logic [7:0] PREF_OFS  = 8'h18;
  localparam logic [7:0] USER_OFS  = 8'h1c;
  localparam logic [7:0] STMP_OFS  = 8'h20;
  localparam logic [7:0] GRP_OFS   = 8'h40;
  // control register fields
  localparam int CTRL_DMODE_LSB = 0;
  localparam int CTRL_CURVE_LSB = 2;
  localparam int CTRL_HARM_LSB  = 4;
  localparam int CTRL_INSEL_LSB = 8;
  localparam int CTRL_PCT_BIT   = 10;
  localparam int CMD_CLR_BIT    = 0;
  localparam int GRP_DLY_LSB    = 16;
  localparam logic [31:0] CTRL_RST = 32'h0000_0010;
  localparam logic [31:0] USER_RST = 32'h0000_0100;
  localparam logic [31:0] GRP_RST  = 32'h0000_0014;
  localparam logic [1:0] INSEL_PHASE = 2'h0;
  localparam logic [1:0] INSEL_RES1  = 2'h1;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    dm_instant        = 2'h0,
    fixed_delay_mode  = 2'h1,
    inverse_time_mode = 2'h2
  } hos_dmode_e;

  typedef enum logic [1:0] {
    cv_iec  = 2'h0,
    cv_ansi = 2'h1,
    cv_user = 2'h2
  } hos_curve_e;

  typedef enum logic [3:0] {
    st_normal  = 4'b0001,
    st_start   = 4'b0010,
    st_trip    = 4'b0100,
    st_blocked = 4'b1000
  } hos_state_e;
endpackage

//--- include/hos_time_if.sv
// evaluation tick and millisecond stamp shared inside the stage
`timescale 1ns/1ps
interface hos_time_if;
  logic        tick;
  logic [31:0] stamp;
  modport src (output tick, output stamp);
  modport snk (input tick, input stamp);
endinterface

//--- verif/hos_props.sv
// port-level checks of the harmonic overcurrent stage
`timescale 1ns/1ps
module hos_props
  import hos_pkg::*;
#(
  parameter int MS_CYCLES = HOS_MS_CYCLES
)(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  input wire logic        start_out,
  input wire logic        trip_out,
  input wire logic        blocked_out,
  input wire logic        event_valid,
  input wire logic [5:0]  event_flags
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  out_event_a: assert property ($changed({start_out, trip_out, blocked_out})
    |-> event_valid) else $error("output moved without event");
  start_flag_a: assert property ($rose(start_out)
    |-> event_flags[0] && !event_flags[1]) else $error("start on flag");
  trip_off_a: assert property ($fell(trip_out)
    |-> event_flags[3]) else $error("trip off flag");
  block_flag_a: assert property ($rose(blocked_out)
    |-> event_flags[4]) else $error("blocked on flag");
  block_excl_a: assert property (blocked_out
    |-> !start_out && !trip_out) else $error("blocked with start");
  tick_gap_a: assert property (event_valid
    |=> (!event_valid) [*8]) else $error("events too close");
  bresp_hold_a: assert property (bvalid && !bready
    |=> bvalid && $stable(bresp)) else $error("write answer dropped");
  rdata_hold_a: assert property (rvalid && !rready
    |=> rvalid && $stable(rdata)) else $error("read answer dropped");
  read_answer_a: assert property (arvalid && arready
    |=> rvalid && !arready) else $error("read answer late");
endmodule

//--- verif/hos_spec_src.sv
// upstream spectrum source refreshing every channel each period
`timescale 1ns/1ps
module hos_spec_src
  import hos_pkg::*;
#(
  parameter int MS_CYCLES = HOS_MS_CYCLES
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [3:0]       harm_comp,
  input  wire logic [2:0]       hot_chan,
  input  wire logic [MAG_W-1:0] fund_mag,
  input  wire logic [MAG_W-1:0] harm_mag,
  output logic                  spec_valid,
  output logic      [2:0]       spec_chan,
  output logic      [3:0]       spec_comp,
  output logic      [MAG_W-1:0] spec_mag
);
  localparam int PERIOD = EVAL_PERIOD_MS * MS_CYCLES;
  int cnt_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || cnt_reg == PERIOD - 1)
      cnt_reg <= 0;
    else
      cnt_reg <= cnt_reg + 1;
  end

  // harmonic only on the hot channel; idle words scramble the bus
  always_ff @(posedge aclk)
  begin
    if (aresetn && cnt_reg < 2 * NUM_CHAN)
    begin
      spec_valid <= 1'b1;
      spec_chan  <= 3'(cnt_reg / 2);
      spec_comp  <= cnt_reg[0] ? harm_comp : 4'(COMP_FUND);
      spec_mag   <= !cnt_reg[0] ? fund_mag :
                    (3'(cnt_reg / 2) == hot_chan ? harm_mag : '0);
    end
    else
    begin
      spec_valid <= 1'b0;
      spec_chan  <= spec_chan + 3'h1;
      spec_comp  <= ~spec_comp;
      spec_mag   <= ~spec_mag;
    end
  end
endmodule

//--- verif/tb.sv
// self-checking bench of the harmonic overcurrent stage
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import hos_pkg::*;
;
  localparam int MS = 10;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, spec_valid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, event_stamp;
  logic [2:0] spec_chan, group_sel = 3'h0, hot = 3'h1;
  logic [3:0] spec_comp, harm_comp = 4'h1;
  logic [15:0] spec_mag, fund = 16'h03e8, harm = 16'h0032;
  logic block_in = 1'b0, start_out, trip_out, blocked_out, event_valid;
  logic [5:0] event_flags;
  int mismatches = 0, cmp_count = 0;
  integer seed = 32'h781f;

  always #5 aclk = ~aclk;

  hos_stage #(.MS_CYCLES(MS)) dut (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .spec_valid, .spec_chan, .spec_comp, .spec_mag, .group_sel, .block_in,
    .start_out, .trip_out, .blocked_out, .event_valid, .event_flags,
    .event_stamp);
  hos_spec_src #(.MS_CYCLES(MS)) src (.aclk, .aresetn, .harm_comp,
    .hot_chan(hot), .fund_mag(fund), .harm_mag(harm), .spec_valid,
    .spec_chan, .spec_comp, .spec_mag);

  task automatic tally_and_finish;
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic hang;
    mismatches++;
    tally_and_finish();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    logic ad = 1'b0;
    logic wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge aclk);
      if (bready && bvalid === 1'b1)
        break;
      // late ready makes the slave hold its answer
      if (ad && wd && bvalid === 1'b1)
        bready <= 1'b1;
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    if (n == 60)
      hang();
    `CHK(bresp, er)
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er = RESP_OKAY);
    int n;
    logic ad = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge aclk);
      if (rready && rvalid === 1'b1)
        break;
      if (ad && rvalid === 1'b1)
        rready <= 1'b1;
      if (!ad && arready === 1'b1)
      begin
        ad = 1'b1;
        arvalid <= 1'b0;
      end
    end
    if (n == 60)
      hang();
    `CHK({rresp, rdata}, {er, e})
    rready <= 1'b0;
  endtask

  task automatic wait_ev(output logic [5:0] f);
    int n;
    for (n = 0; n < 600 && event_valid !== 1'b1; n++)
      @(posedge aclk);
    if (n == 600)
      hang();
    f = event_flags;
  endtask

  initial
  begin
    logic [5:0] f;
    logic [31:0] v, s0;
    time t0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(CTRL_OFS, CTRL_RST);
    rd(USER_OFS, USER_RST);
    rd(GRP_OFS, GRP_RST);
    rd(TCNT_OFS, 32'h0);
    rd(8'h30, 32'h0, RESP_SLVERR);
    wr(8'h30, 32'h1, RESP_SLVERR);
    for (int g = 0; g < NUM_GROUPS; g++)
    begin
      v = $random(seed) | 32'h0000_8000; // no random early pick-up
      wr(GRP_OFS + 8'(4 * g), v);
      rd(GRP_OFS + 8'(4 * g), v);
    end
    // fixed delay of two ticks on phase b, harmonic index 1
    wr(CTRL_OFS, 32'h11);
    wr(GRP_OFS, 32'h0002_0064);
    wr(GRP_OFS + 8'h4, 32'h0000_fff0);
    repeat (250) @(posedge aclk);
    harm <= 16'h00c8;
    wait_ev(f);
    `CHK({f, start_out, trip_out}, 8'h06)
    s0 = event_stamp;
    t0 = $time;
    rd(PREF_OFS, 32'h32);
    @(posedge aclk);
    wait_ev(f);
    `CHK({f[2], trip_out}, 2'b11)
    `CHK($time - t0, time'(2 * EVAL_PERIOD_MS * MS * 10))
    `CHK(event_stamp - s0, 32'(2 * EVAL_PERIOD_MS))
    harm <= 16'h0062;
    repeat (200) @(posedge aclk);
    `CHK(trip_out, 1'b1)
    harm <= 16'h0060;
    wait_ev(f);
    `CHK({start_out, trip_out}, 2'b00)
    // instant mode in percent of fundamental
    wr(CTRL_OFS, 32'h410);
    wr(GRP_OFS, 32'h0000_07d0);
    harm <= 16'h00fa;
    @(posedge aclk);
    wait_ev(f);
    `CHK({f[0], f[2], trip_out}, 3'b111)
    rd(TCNT_OFS, 32'h2);
    harm <= 16'h0000;
    @(posedge aclk);
    wait_ev(f);
    // blocked pick-up on residual one
    block_in <= 1'b1;
    hot <= 3'(CH_RES_ONE);
    wr(CTRL_OFS, 32'h111);
    wr(GRP_OFS, 32'h0002_0064);
    harm <= 16'h00c8;
    wait_ev(f);
    `CHK({f[4], blocked_out, start_out}, 3'b110)
    rd(BCNT_OFS, 32'h1);
    group_sel <= 3'h1;
    repeat (10) @(posedge aclk);
    rd(STAT_OFS, 32'h0000_0031);
    @(posedge aclk);
    wait_ev(f);
    `CHK(blocked_out, 1'b0)
    wr(CMD_OFS, 32'h1);
    rd(SCNT_OFS, 32'h0);
    rd(TCNT_OFS, 32'h0);
    // inverse ansi curve on residual two, step (200-100)^2>>8 = 39
    block_in <= 1'b0;
    group_sel <= 3'h0;
    hot <= 3'(CH_RES_TWO);
    wr(CTRL_OFS, 32'h216);
    wr(GRP_OFS, 32'h0001_0064);
    wait_ev(f);
    `CHK({f, start_out}, 7'h03)
    t0 = $time;
    @(posedge aclk);
    wait_ev(f);
    `CHK({f[2], trip_out}, 2'b11)
    // seven steps of 39 are the first to reach the limit of 256
    `CHK($time - t0, time'(7 * EVAL_PERIOD_MS * MS * 10))
    tally_and_finish();
  end
endmodule

bind hos_stage hos_props #(.MS_CYCLES(MS_CYCLES)) props (.aclk, .aresetn,
  .arvalid, .arready, .rvalid, .rready, .rdata, .bvalid, .bready, .bresp,
  .start_out, .trip_out, .blocked_out, .event_valid, .event_flags);

//--- verilog/hos_prefault.sv
// sliding average of the monitored magnitude over the last ticks
`timescale 1ns/1ps
module hos_prefault
  import hos_pkg::*;
#(
  parameter int DEPTH = PREFAULT_DEPTH
)(
  input  wire logic             aclk,
  input  wire logic             aresetn,
  hos_time_if.snk               tb,
  input  wire logic [MAG_W-1:0] sample,
  output logic      [MAG_W-1:0] avg
);
  logic [MAG_W-1:0] hist_reg [DEPTH];
  logic [MAG_W+7:0] sum;

  always_comb
  begin
    sum = '0;
    for (int i = 0; i < DEPTH; i++)
      sum = sum + (MAG_W+8)'(hist_reg[i]);
  end

  // average reflects only ticks before the current one
  assign avg = MAG_W'(sum / (MAG_W+8)'(DEPTH));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (int i = 0; i < DEPTH; i++)
        hist_reg[i] <= '0;
    end
    else if (tb.tick)
    begin
      hist_reg[0] <= sample;
      for (int i = 1; i < DEPTH; i++)
        hist_reg[i] <= hist_reg[i-1];
    end
  end
endmodule

//--- verilog/hos_stage.sv
// harmonic overcurrent stage with axi4-lite settings access
// Operation
// RL1 - evaluate the configured harmonic, absolute or relative to channel RMS; the code relates it to the fundamental instead
// RL2 - eight parameter sets, one active, picked by a shared select input
// RL3 - setting and group changes act live without a restart
// RL4 - instant mode or delayed mode, fixed or inverse-time
// RL5 - inverse delay offers IEC, ANSI and user-defined curves
// RL6 - start, trip and blocked outputs for direct use
// RL7 - time-stamped ON and OFF events for all three outputs
// RL8 - instant mode emits start and trip events with one stamp
// RL9 - event stamps count whole milliseconds
// RL10 - cumulative start, trip, blocked counters, clearable on request
// RL11 - three phases share one common threshold
// RL12 - select, process, saturate, compare, block, delay, then output
// RL13 - five channels carrying fundamental and eleven harmonics
// RL14 - inputs refreshed and evaluated every 5 ms
// RL15 - monitored value per unit or percent of the fundamental
// RL16 - record 20 ms averaged magnitude before start or trip
// RL17 - software supplies channel, harmonic order and monitoring type
// RL18 - start usable at once, trip after the delay
// RL19 - pick-up releases below 97 percent of threshold
// RL20 - pick-up under active block asserts blocked instead of start
// RL21 - delay timers step per 5 ms tick and clear on release
`timescale 1ns/1ps
module hos_stage
  import hos_pkg::*;
#(
  parameter int MS_CYCLES = HOS_MS_CYCLES
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              spec_valid,
  input  wire logic [2:0]        spec_chan,
  input  wire logic [3:0]        spec_comp,
  input  wire logic [MAG_W-1:0]  spec_mag,
  input  wire logic [2:0]        group_sel,
  input  wire logic              block_in,
  output logic                   start_out,
  output logic                   trip_out,
  output logic                   blocked_out,
  output logic                   event_valid,
  output logic [5:0]             event_flags,
  output logic [31:0]            event_stamp
);
  hos_time_if tb ();
  logic [31:0]      ctrl_reg, user_reg, grp_reg [NUM_GROUPS];
  logic [MAG_W-1:0] harm_reg [NUM_CHAN], fund_reg [NUM_CHAN];
  logic [2:0]       grp_s1_reg, grp_s2_reg;
  logic             blk_s1_reg, blk_s2_reg;
  logic [2:0]       pick_reg, pick_next;
  logic [39:0]      diff [NUM_PHASE];
  logic [MAG_W-1:0] sample, avg, exc;
  logic [MAG_W-1:0] prefault_reg;
  logic [31:0]      acc_reg, acc_next, inc;
  logic [31:0]      scnt_reg, tcnt_reg, bcnt_reg;
  hos_state_e       state_reg, state_next;
  logic             pick_any, dly_done, clr;
  logic             aw_full_reg, w_full_reg;
  logic [7:0]       awaddr_reg;
  logic [31:0]      wdata_reg;
  logic [3:0]       wstrb_reg;
  logic             wr_fire;
  logic [31:0]      rd_word;
  logic             rd_hit;
  logic [5:0]       ev;

  hos_dmode_e dmode;
  hos_curve_e curve;
  logic [3:0] harm_sel;
  logic [1:0] insel;
  logic       pct;
  logic [15:0] thr, dly;

  assign dmode    = hos_dmode_e'(ctrl_reg[CTRL_DMODE_LSB +: 2]);      // [RL4]
  assign curve    = hos_curve_e'(ctrl_reg[CTRL_CURVE_LSB +: 2]);      // [RL5]
  assign harm_sel = ctrl_reg[CTRL_HARM_LSB +: 4];                     // [RL17]
  assign insel    = ctrl_reg[CTRL_INSEL_LSB +: 2];
  assign pct      = ctrl_reg[CTRL_PCT_BIT];
  // live lookup of the selected group, no restart needed
  assign thr = grp_reg[grp_s2_reg][15:0];                       // [RL2] [RL3]
  assign dly = grp_reg[grp_s2_reg][GRP_DLY_LSB +: 16];

  hos_timebase #(.MS_CYCLES(MS_CYCLES)) u_tb (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tb      (tb.src)
  );

  hos_prefault u_pf (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tb      (tb.snk),
    .sample  (sample),
    .avg     (avg)
  );

  // pins from outside the clock domain
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      grp_s1_reg <= 3'h0;
      grp_s2_reg <= 3'h0;
      blk_s1_reg <= 1'b0;
      blk_s2_reg <= 1'b0;
    end
    else
    begin
      grp_s1_reg <= group_sel;
      grp_s2_reg <= grp_s1_reg;
      blk_s1_reg <= block_in;
      blk_s2_reg <= blk_s1_reg;
    end
  end

  // latch fundamental and the chosen harmonic per channel
  genvar c;
  generate
    for (c = 0; c < NUM_CHAN; c++)
    begin : g_chan
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          harm_reg[c] <= '0;
          fund_reg[c] <= '0;
        end
        else if (spec_valid && spec_chan == 3'(c))
        begin                                                  // [RL13] [RL14]
          if (spec_comp == 4'(COMP_FUND))
            fund_reg[c] <= spec_mag;
          if (spec_comp == harm_sel)
            harm_reg[c] <= spec_mag;                                 // [RL1]
        end
      end
    end
  endgenerate

  // one comparator per phase slot, all against the same threshold
  genvar k;
  generate
    for (k = 0; k < NUM_PHASE; k++)
    begin : g_slot
      logic [2:0]       src;
      logic [MAG_W-1:0] h;
      logic [39:0]      lhs, rhs;
      logic             over, under, sat;
      always_comb
      begin
        src = (insel == INSEL_PHASE) ? 3'(k) :                       // [RL12]
              (insel == INSEL_RES1) ? 3'(CH_RES_ONE) : 3'(CH_RES_TWO);
        h   = harm_reg[src];
        lhs = pct ? 40'(h) * 40'(PCT_SCALE) : 40'(h);               // [RL15]
        rhs = pct ? 40'(thr) * 40'(fund_reg[src]) : 40'(thr);       // [RL11]
        // a clipped magnitude is never trusted to be below pick-up
        sat   = (h == {MAG_W{1'b1}});
        over  = sat || (lhs >= rhs);
        under = !sat && (48'(lhs) * 48'(PCT_FULL) <
                         48'(rhs) * 48'(RESET_PCT));                 // [RL19]
        pick_next[k] = pick_reg[k] ? !under : over;
        diff[k] = (pick_next[k] && lhs > rhs) ? lhs - rhs : 40'h0;
      end
    end
  endgenerate

  always_comb
  begin
    sample = '0;
    exc    = '0;
    for (int i = 0; i < NUM_PHASE; i++)
    begin
      if (harm_reg[(insel == INSEL_PHASE) ? i : 0] > sample && insel ==
          INSEL_PHASE)
        sample = harm_reg[i];
      if (diff[i][39:16] != 24'h0)
        exc = {MAG_W{1'b1}};
      else if (diff[i][15:0] > exc)
        exc = diff[i][15:0];
    end
    if (insel != INSEL_PHASE)
      sample = harm_reg[(insel == INSEL_RES1) ? CH_RES_ONE : CH_RES_TWO];
  end

  assign pick_any = |pick_next;

  // inverse step grows with the excess over the threshold
  always_comb
  begin
    unique case (curve)
      cv_ansi: inc = (32'(exc) * 32'(exc)) >> IEC_SHIFT;
      cv_user: inc = (32'(exc) * 32'(user_reg[15:0])) >> IEC_SHIFT;
      default: inc = 32'(exc);
    endcase
    if (dmode == inverse_time_mode)
    begin
      acc_next = acc_reg + inc;
      dly_done = acc_next >= {8'h0, dly, 8'h0};                      // [RL5]
    end
    else
    begin
      acc_next = acc_reg + 32'h1;
      dly_done = acc_next >= 32'(dly);
    end
  end

  always_comb
  begin
    state_next = state_reg;
    if (!pick_any)
      state_next = st_normal;
    else if (blk_s2_reg)
      state_next = st_blocked;                                      // [RL20]
    else
      unique case (state_reg)
        st_normal, st_blocked:
          state_next = (dmode == dm_instant) ? st_trip : st_start;  // [RL4]
        st_start:
          state_next = dly_done ? st_trip : st_start;               // [RL18]
        st_trip:
          state_next = st_trip;
      endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= st_normal;
      pick_reg  <= 3'h0;
      acc_reg   <= 32'h0;
    end
    else if (tb.tick)
    begin                                                           // [RL14]
      state_reg <= state_next;
      pick_reg  <= pick_next;
      acc_reg   <= (state_reg == st_start && state_next == st_start)
                   ? acc_next : 32'h0;                              // [RL21]
    end
  end

  // events compare the new outputs with the ones on the pins
  always_comb
  begin
    ev[0] = !start_out && state_next inside {st_start, st_trip};
    ev[1] = start_out && !(state_next inside {st_start, st_trip});
    ev[2] = !trip_out && state_next == st_trip;
    ev[3] = trip_out && state_next != st_trip;
    ev[4] = !blocked_out && state_next == st_blocked;
    ev[5] = blocked_out && state_next != st_blocked;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      start_out   <= 1'b0;
      trip_out    <= 1'b0;
      blocked_out <= 1'b0;
      event_valid <= 1'b0;
      event_flags <= 6'h0;
      event_stamp <= 32'h0;
    end
    else
    begin
      event_valid <= tb.tick && (|ev);                                // [RL7]
      if (tb.tick)
      begin                                                         // [RL6]
        start_out   <= state_next inside {st_start, st_trip};
        trip_out    <= state_next == st_trip;
        blocked_out <= state_next == st_blocked;
        // instant start and trip land in one word with one stamp
        event_flags <= ev;                                            // [RL8]
        event_stamp <= tb.stamp;                                      // [RL9]
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      prefault_reg <= '0;
    else if (tb.tick && (ev[0] || ev[2]))
      prefault_reg <= avg;                                           // [RL16]
  end

  // a count arriving with the clear survives as one
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      scnt_reg <= 32'h0;
      tcnt_reg <= 32'h0;
      bcnt_reg <= 32'h0;
    end
    else
    begin                                                           // [RL10]
      if (tb.tick && ev[0])
        scnt_reg <= clr ? 32'h1 : scnt_reg + 32'h1;
      else if (clr)
        scnt_reg <= 32'h0;
      if (tb.tick && ev[2])
        tcnt_reg <= clr ? 32'h1 : tcnt_reg + 32'h1;
      else if (clr)
        tcnt_reg <= 32'h0;
      if (tb.tick && ev[4])
        bcnt_reg <= clr ? 32'h1 : bcnt_reg + 32'h1;
      else if (clr)
        bcnt_reg <= 32'h0;
    end
  end

  // write channel: address and data taken in either order
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid;
  assign clr     = wr_fire && awaddr_reg == CMD_OFS && wstrb_reg[0] &&
                   wdata_reg[CMD_CLR_BIT];

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  be);
    for (int b = 0; b < 4; b++)
      if (be[b])
        old[8*b +: 8] = nw[8*b +: 8];
    return old;
  endfunction

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg <= 1'b0;
      w_full_reg  <= 1'b0;
      awready     <= 1'b0;
      wready      <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= RESP_OKAY;
      awaddr_reg  <= 8'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        aw_full_reg <= 1'b1;
        awaddr_reg  <= awaddr;
      end
      if (wvalid && wready)
      begin
        w_full_reg <= 1'b1;
        wdata_reg  <= wdata;
        wstrb_reg  <= wstrb;
      end
      awready <= !aw_full_reg && !(awvalid && awready) && !wr_fire;
      wready  <= !w_full_reg && !(wvalid && wready) && !wr_fire;
      if (wr_fire)
      begin
        aw_full_reg <= 1'b0;
        w_full_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp <= (awaddr_reg inside {CTRL_OFS, CMD_OFS, USER_OFS} ||
                  awaddr_reg[7:5] == GRP_OFS[7:5]) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_reg <= CTRL_RST;
      user_reg <= USER_RST;
      for (int g = 0; g < NUM_GROUPS; g++)
        grp_reg[g] <= GRP_RST;
    end
    else if (wr_fire)
    begin
      if (awaddr_reg == CTRL_OFS)
        ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg == USER_OFS)
        user_reg <= merge(user_reg, wdata_reg, wstrb_reg);
      if (awaddr_reg[7:5] == GRP_OFS[7:5])
        grp_reg[awaddr_reg[4:2]] <= merge(grp_reg[awaddr_reg[4:2]],
                                          wdata_reg, wstrb_reg);
    end
  end

  always_comb
  begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    if (araddr[7:5] == GRP_OFS[7:5])
      rd_word = grp_reg[araddr[4:2]];
    else
      unique case (araddr)
        CTRL_OFS: rd_word = ctrl_reg;
        CMD_OFS:  rd_word = 32'h0;
        STAT_OFS: rd_word = {24'h0, grp_s2_reg, state_reg, blocked_out};
        SCNT_OFS: rd_word = scnt_reg;
        TCNT_OFS: rd_word = tcnt_reg;
        BCNT_OFS: rd_word = bcnt_reg;
        PREF_OFS: rd_word = 32'(prefault_reg);
        USER_OFS: rd_word = user_reg;
        STMP_OFS: rd_word = tb.stamp;
        default:  rd_hit  = 1'b0;
      endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= RESP_OKAY;
    end
    else if (arvalid && arready)
    begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_word;
      rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rvalid && rready)
    begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end
    else if (!rvalid)
      arready <= 1'b1;
  end
endmodule

//--- verilog/hos_timebase.sv
// millisecond stamp counter and five millisecond evaluation tick
`timescale 1ns/1ps
module hos_timebase
  import hos_pkg::*;
#(
  parameter int MS_CYCLES = HOS_MS_CYCLES
)(
  input  wire logic aclk,
  input  wire logic aresetn,
  hos_time_if.src   tb
);
  logic [31:0] cyc_reg;
  logic [3:0]  ms5_reg;
  logic [31:0] stamp_reg;
  logic        tick_reg;
  logic        ms_wrap;

  assign ms_wrap  = (cyc_reg == 32'(MS_CYCLES - 1));
  assign tb.tick  = tick_reg;
  assign tb.stamp = stamp_reg;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cyc_reg   <= 32'h0;
      stamp_reg <= 32'h0;
    end
    else if (ms_wrap)
    begin
      cyc_reg   <= 32'h0;
      stamp_reg <= stamp_reg + 32'h1;
    end
    else
      cyc_reg <= cyc_reg + 32'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ms5_reg  <= 4'h0;
      tick_reg <= 1'b0;
    end
    else
    begin
      tick_reg <= ms_wrap && (ms5_reg == 4'(EVAL_PERIOD_MS - 1));
      if (ms_wrap)
        ms5_reg <= (ms5_reg == 4'(EVAL_PERIOD_MS - 1)) ? 4'h0
                                                       : ms5_reg + 4'h1;
    end
  end
endmodule
